// ---- verilog/lag_pkg.sv ----
`default_nettype none
package lag_pkg;
   // Port and group counts
   localparam int NPORT = 12;
   localparam int NGRP = 6;
   localparam int MIN_PAIR = 2;

   // Register regions, 64 bytes each, one word per port except the single hash word
   localparam logic [2:0] RG_HASH = 3'h0;
   localparam logic [2:0] RG_GRP = 3'h1;
   localparam logic [2:0] RG_LCFG = 3'h2;
   localparam logic [2:0] RG_PRIO = 3'h3;
   localparam logic [2:0] RG_STAT = 3'h4;
   localparam int RG_LSB = 6;
   localparam int IDX_LSB = 2;

   // Hash contributor bits and their reset value
   localparam int HB_SMAC = 0;
   localparam int HB_DMAC = 1;
   localparam int HB_IP = 2;
   localparam int HB_L4 = 3;
   localparam logic [3:0] HASH_RST = 4'hD;

   // Negotiation config word
   localparam int LB_EN = 0;
   localparam int LB_PASV = 1;
   localparam int LB_SLOW = 2;
   localparam int LB_SPEC = 3;
   localparam int LB_KEY = 16;
   localparam logic [31:0] LCFG_RST = 32'h0001_0000;
   localparam logic [31:0] LCFG_WMASK = 32'hFFFF_000F;
   localparam logic [2:0] GRP_RST = 3'h0;
   localparam logic [15:0] PRIO_RST = 16'h8000;

   // Status word bits
   localparam int SB_LINK = 0;
   localparam int SB_STAT = 1;
   localparam int SB_ELIG = 2;
   localparam int SB_BUND = 3;
   localparam int SB_ACT = 4;
   localparam int SB_HEARD = 5;
   localparam int SB_KEY = 16;

   // Link speed codes and the automatic keys they give
   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_100 = 2'h1;
   localparam logic [1:0] SPD_1G = 2'h2;
   localparam logic [15:0] KEY_10 = 16'h0001;
   localparam logic [15:0] KEY_100 = 16'h0002;
   localparam logic [15:0] KEY_1G = 16'h0003;

   // Negotiation packet periods
   localparam int CLK_HZ = 200000000;
   localparam int FAST_PERIOD_S = 1;
   localparam int SLOW_PERIOD_S = 30;
   localparam int CYC_PER_SEC = CLK_HZ;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_RUN = 2'b10
   } lag_tx_state_type;
endpackage
`default_nettype wire

// ---- verilog/lag_hash.sv ----
`default_nettype none
module lag_hash
   import lag_pkg::*;
(
   // Frame header fields
   input wire logic [47:0] smac,
   input wire logic [47:0] dmac,
   input wire logic [31:0] sip,
   input wire logic [31:0] dip,
   input wire logic [15:0] sport,
   input wire logic [15:0] dport,
   // Contributor enables and candidate members
   input wire logic [3:0] hash_en,
   input wire logic [NPORT-1:0] mask,
   // Chosen member
   output logic [3:0] sel
);
   logic [15:0] h;
   logic [7:0] h8;
   logic [3:0] cnt;
   logic [3:0] nth;
   logic [3:0] seen;

   // Fold only the enabled fields, so one flow always hashes alike
   always_comb begin
      h = 16'h0000;
      if (hash_en[HB_SMAC]) begin
         h = h ^ smac[47:32] ^ smac[31:16] ^ smac[15:0];
      end
      if (hash_en[HB_DMAC]) begin
         h = h ^ dmac[47:32] ^ dmac[31:16] ^ dmac[15:0];
      end
      if (hash_en[HB_IP]) begin
         h = h ^ sip[31:16] ^ sip[15:0] ^ dip[31:16] ^ dip[15:0];
      end
      if (hash_en[HB_L4]) begin
         h = h ^ sport ^ dport;
      end
      h8 = h[15:8] ^ h[7:0];
   end

   // Pick the nth set bit of the mask, n = hash mod members
   always_comb begin
      cnt = 4'h0;
      for (int j = 0; j < NPORT; j++) begin
         cnt = cnt + {3'h0, mask[j]};
      end
      nth = (cnt == 4'h0) ? 4'h0 : 4'((h8 % {4'h0, cnt}));
      seen = 4'h0;
      sel = 4'h0;
      for (int j = 0; j < NPORT; j++) begin
         if (mask[j]) begin
            if (seen == nth) begin
               sel = 4'(j);
            end
            seen = seen + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verilog/lag_pdu_timer.sv ----
`default_nettype none
module lag_pdu_timer
   import lag_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Control
   input wire logic sec_tick,
   input wire logic run,
   input wire logic slow,
   // Send request, one cycle
   output logic pdu_req
);
   lag_tx_state_type state_r, state_nxt;
   logic [4:0] sec_r, sec_nxt;
   logic req_r, req_nxt;
   logic [4:0] period;

   // First packet at once, then one per period
   always_comb begin
      period = slow ? 5'(SLOW_PERIOD_S) : 5'(FAST_PERIOD_S);
      state_nxt = state_r;
      sec_nxt = sec_r;
      req_nxt = 1'b0;
      unique case (state_r)
         TX_IDLE: begin
            if (run) begin
               req_nxt = 1'b1;
               sec_nxt = 5'h00;
               state_nxt = TX_RUN;
            end
         end
         TX_RUN: begin
            if (!run) begin
               state_nxt = TX_IDLE;
            end else if (sec_tick && !req_r) begin
               if (sec_r + 5'h01 >= period) begin
                  req_nxt = 1'b1;
                  sec_nxt = 5'h00;
               end else begin
                  sec_nxt = sec_r + 5'h01;
               end
            end
         end
         default: state_nxt = TX_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= TX_IDLE;
         sec_r <= 5'h00;
         req_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sec_r <= sec_nxt;
         req_r <= req_nxt;
      end
   end

   assign pdu_req = req_r;
endmodule
`default_nettype wire

// ---- verilog/lag_selector.sv ----
// Summary of operation
// - Source MAC hash input, on after reset
// - Destination MAC hash input, off after reset
// - IP address hash input, on after reset
// - TCP/UDP port hash input, on after reset
// - One group per port; normal means unbundled
// - Reset leaves every port ungrouped
// - Static member needs full duplex, same speed
// - Negotiated member needs link up, full duplex
// - Further member must match aggregated speed
// - Negotiated member VLAN attributes must match
// - Active starts, passive answers, passive pair fails
// - Negotiation needs two ports, same partner
// - Key 1..65535, auto key from speed
// - Only equal keys share a group
// - Packets each second fast, thirty slow
// - Priority 1..65535, default 32768, lower wins
`default_nettype none
module lag_selector
   import lag_pkg::*;
#(
   parameter int SEC_CYCLES = CYC_PER_SEC * FAST_PERIOD_S,
   parameter int MAX_ACTIVE = 8,
   parameter int VW = 12,
   parameter int PIDW = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Per-port link state
   input wire logic [NPORT-1:0] link_up,
   input wire logic [NPORT-1:0] full_dup,
   input wire logic [2*NPORT-1:0] port_speed,
   input wire logic [VW*NPORT-1:0] port_vlan,
   input wire logic [PIDW*NPORT-1:0] partner_id,
   // Negotiation packets
   input wire logic [NPORT-1:0] pdu_rx,
   output logic [NPORT-1:0] pdu_tx,
   output logic [NPORT-1:0] member_act,
   // Frame in
   input wire logic frm_valid,
   input wire logic [3:0] frm_dst,
   input wire logic [47:0] frm_smac,
   input wire logic [47:0] frm_dmac,
   input wire logic [31:0] frm_sip,
   input wire logic [31:0] frm_dip,
   input wire logic [15:0] frm_sport,
   input wire logic [15:0] frm_dport,
   // Egress decision
   output logic egr_valid,
   output logic [3:0] egr_port
);
   // Register and state storage
   logic [3:0] hash_r, hash_nxt;
   logic [2:0] grp_r [NPORT], grp_nxt [NPORT];
   logic [31:0] lcfg_r [NPORT], lcfg_nxt [NPORT];
   logic [15:0] prio_r [NPORT], prio_nxt [NPORT];
   logic [NPORT-1:0] heard_r, heard_nxt;
   logic [NPORT-1:0] stat_r, stat_nxt;
   logic [NPORT-1:0] elig_r, elig_nxt;
   logic [NPORT-1:0] bund_r, bund_nxt;
   logic [NPORT-1:0] act_r, act_nxt;
   logic [NPORT-1:0] mem_r, mem_nxt;
   logic [NPORT-1:0] set_r [NPORT], set_nxt [NPORT];
   logic [31:0] sec_cnt_r, sec_cnt_nxt;
   logic sec_tick_r, sec_tick_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic egr_valid_r, egr_valid_nxt;
   logic [3:0] egr_port_r, egr_port_nxt;
   // Combinational helpers
   logic [1:0] spd [NPORT];
   logic [15:0] ekey [NPORT];
   logic [NPORT-1:0] upfd, neg;
   logic [NPORT-1:0] match [NPORT];
   logic [3:0] hash_sel;
   logic [NPORT-1:0] dst_mask;
   logic accept;

   // Register decode shared by read and write paths
   function automatic logic reg_hit(input logic [31:0] a,
                                    input logic [2:0] rg);
      logic [3:0] idx;
      idx = a[IDX_LSB +: 4];
      reg_hit = (a[31:RG_LSB+3] == '0) && (a[RG_LSB +: 3] == rg) &&
                (a[1:0] == 2'h0) &&
                ((rg == RG_HASH) ? (idx == 4'h0) : (idx < 4'(NPORT)));
   endfunction

   // Key follows link speed unless a specific value is set
   function automatic logic [15:0] auto_key(input logic [1:0] s);
      unique case (s)
         SPD_10: auto_key = KEY_10;
         SPD_100: auto_key = KEY_100;
         default: auto_key = KEY_1G;
      endcase
   endfunction

   // Per-port eligibility and pairwise match
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         spd[i] = port_speed[2*i +: 2];
         ekey[i] = lcfg_r[i][LB_SPEC] ? lcfg_r[i][LB_KEY +: 16] :
                   auto_key(spd[i]);
         upfd[i] = link_up[i] & full_dup[i];
         elig_nxt[i] = lcfg_r[i][LB_EN] & upfd[i];
         // A passive port joins only once spoken to
         neg[i] = elig_nxt[i] & (~lcfg_r[i][LB_PASV] | heard_r[i]);
      end
      for (int i = 0; i < NPORT; i++) begin
         for (int j = 0; j < NPORT; j++) begin
            match[i][j] = neg[i] && neg[j] &&
               (ekey[i] == ekey[j]) &&
               (partner_id[PIDW*i +: PIDW] ==
                partner_id[PIDW*j +: PIDW]) &&
               (port_vlan[VW*i +: VW] == port_vlan[VW*j +: VW]) &&
               (spd[i] == spd[j]);
         end
      end
   end

   // Static admission, bundling, priority ranking, member sets
   always_comb begin
      logic found;
      logic [3:0] rank;
      logic [3:0] peers;
      found = 1'b0;
      rank = 4'h0;
      peers = 4'h0;
      for (int i = 0; i < NPORT; i++) begin
         // First usable port of the group sets the speed
         found = 1'b0;
         stat_nxt[i] = 1'b0;
         if (grp_r[i] != GRP_RST && !lcfg_r[i][LB_EN] && upfd[i]) begin
            stat_nxt[i] = 1'b1;
            for (int j = 0; j < NPORT; j++) begin
               if (!found && grp_r[j] == grp_r[i] && upfd[j] &&
                   !lcfg_r[j][LB_EN]) begin
                  found = 1'b1;
                  if (spd[j] != spd[i]) begin
                     stat_nxt[i] = 1'b0;
                  end
               end
            end
         end
         peers = 4'h0;
         rank = 4'h0;
         for (int j = 0; j < NPORT; j++) begin
            peers = peers + {3'h0, match[i][j]};
            if (j != i && match[i][j] &&
                (prio_r[j] < prio_r[i] ||
                 (prio_r[j] == prio_r[i] && j < i))) begin
               rank = rank + 4'h1;
            end
         end
         bund_nxt[i] = (peers >= 4'(MIN_PAIR));
         act_nxt[i] = bund_nxt[i] && (rank < 4'(MAX_ACTIVE));
      end
      for (int i = 0; i < NPORT; i++) begin
         mem_nxt[i] = stat_nxt[i] | act_nxt[i];
         for (int j = 0; j < NPORT; j++) begin
            set_nxt[i][j] = (stat_nxt[i] && stat_nxt[j] &&
                             grp_r[i] == grp_r[j]) ||
                            (act_nxt[i] && act_nxt[j] && match[i][j]);
         end
      end
   end

   // Partner heard flag; a fresh packet beats the clear
   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         heard_nxt[i] = pdu_rx[i] | (heard_r[i] & elig_nxt[i]);
      end
   end

   // One-second prescaler for the packet timers
   always_comb begin
      sec_tick_nxt = 1'b0;
      sec_cnt_nxt = sec_cnt_r + 32'h0000_0001;
      if (sec_cnt_r >= 32'(SEC_CYCLES - 1)) begin
         sec_cnt_nxt = 32'h0000_0000;
         sec_tick_nxt = 1'b1;
      end
   end

   // Bus slave: zero wait states, writes land in the data phase
   always_comb begin
      accept = hsel && hready && htrans[1];
      wr_pend_nxt = accept && hwrite;
      addr_nxt = accept ? haddr : addr_r;
      hrdata_nxt = 32'h0000_0000;
      hash_nxt = hash_r;
      for (int i = 0; i < NPORT; i++) begin
         grp_nxt[i] = grp_r[i];
         lcfg_nxt[i] = lcfg_r[i];
         prio_nxt[i] = prio_r[i];
      end
      if (accept && !hwrite) begin
         for (int i = 0; i < NPORT; i++) begin
            if (haddr[IDX_LSB +: 4] == 4'(i)) begin
               if (reg_hit(haddr, RG_GRP)) begin
                  hrdata_nxt = {29'h0, grp_r[i]};
               end
               if (reg_hit(haddr, RG_LCFG)) begin
                  hrdata_nxt = lcfg_r[i];
               end
               if (reg_hit(haddr, RG_PRIO)) begin
                  hrdata_nxt = {16'h0000, prio_r[i]};
               end
               if (reg_hit(haddr, RG_STAT)) begin
                  hrdata_nxt = {ekey[i], 10'h000, heard_r[i], act_r[i],
                                bund_r[i], elig_r[i], stat_r[i],
                                link_up[i]};
               end
            end
         end
         if (reg_hit(haddr, RG_HASH)) begin
            hrdata_nxt = {28'h0, hash_r};
         end
      end
      if (wr_pend_r) begin
         if (reg_hit(addr_r, RG_HASH)) begin
            hash_nxt = hwdata[3:0];
         end
         for (int i = 0; i < NPORT; i++) begin
            if (addr_r[IDX_LSB +: 4] == 4'(i)) begin
               // Out-of-range group numbers are ignored
               if (reg_hit(addr_r, RG_GRP) &&
                   hwdata[2:0] <= 3'(NGRP)) begin
                  grp_nxt[i] = hwdata[2:0];
               end
               if (reg_hit(addr_r, RG_LCFG)) begin
                  lcfg_nxt[i] = hwdata & LCFG_WMASK;
                  if (hwdata[LB_KEY +: 16] == 16'h0000) begin
                     lcfg_nxt[i][LB_KEY +: 16] =
                        lcfg_r[i][LB_KEY +: 16];
                  end
               end
               if (reg_hit(addr_r, RG_PRIO) &&
                   hwdata[15:0] != 16'h0000) begin
                  prio_nxt[i] = hwdata[15:0];
               end
            end
         end
      end
   end

   // Egress: unbundled ports pass, members take the hashed pick
   always_comb begin
      dst_mask = (frm_dst < 4'(NPORT)) ? set_r[frm_dst] : '0;
      egr_valid_nxt = frm_valid && (frm_dst < 4'(NPORT));
      egr_port_nxt = egr_port_r;
      if (frm_valid) begin
         egr_port_nxt = (dst_mask == '0) ? frm_dst : hash_sel;
      end
   end

   lag_hash u_hash (
      .smac(frm_smac),
      .dmac(frm_dmac),
      .sip(frm_sip),
      .dip(frm_dip),
      .sport(frm_sport),
      .dport(frm_dport),
      .hash_en(hash_r),
      .mask(dst_mask),
      .sel(hash_sel)
   );

   // One packet timer per port
   for (genvar g = 0; g < NPORT; g++) begin : g_tmr
      lag_pdu_timer u_tmr (
         .sys_clk(sys_clk),
         .resetn(resetn),
         .sec_tick(sec_tick_r),
         .run(neg[g]),
         .slow(lcfg_r[g][LB_SLOW]),
         .pdu_req(pdu_tx[g])
      );
   end

   // All state registers except the bus response flags
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hash_r <= HASH_RST;
         for (int i = 0; i < NPORT; i++) begin
            grp_r[i] <= GRP_RST;
            lcfg_r[i] <= LCFG_RST;
            prio_r[i] <= PRIO_RST;
            set_r[i] <= '0;
         end
         heard_r <= '0;
         stat_r <= '0;
         elig_r <= '0;
         bund_r <= '0;
         act_r <= '0;
         mem_r <= '0;
         sec_cnt_r <= 32'h0000_0000;
         sec_tick_r <= 1'b0;
         wr_pend_r <= 1'b0;
         addr_r <= 32'h0000_0000;
         hrdata_r <= 32'h0000_0000;
         egr_valid_r <= 1'b0;
         egr_port_r <= 4'h0;
      end else begin
         hash_r <= hash_nxt;
         for (int i = 0; i < NPORT; i++) begin
            grp_r[i] <= grp_nxt[i];
            lcfg_r[i] <= lcfg_nxt[i];
            prio_r[i] <= prio_nxt[i];
            set_r[i] <= set_nxt[i];
         end
         heard_r <= heard_nxt;
         stat_r <= stat_nxt;
         elig_r <= elig_nxt;
         bund_r <= bund_nxt;
         act_r <= act_nxt;
         mem_r <= mem_nxt;
         sec_cnt_r <= sec_cnt_nxt;
         sec_tick_r <= sec_tick_nxt;
         wr_pend_r <= wr_pend_nxt;
         addr_r <= addr_nxt;
         hrdata_r <= hrdata_nxt;
         egr_valid_r <= egr_valid_nxt;
         egr_port_r <= egr_port_nxt;
      end
   end

   // Always ready, always OKAY
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign hrdata = hrdata_r;
   assign member_act = mem_r;
   assign egr_valid = egr_valid_r;
   assign egr_port = egr_port_r;
endmodule
`default_nettype wire

// ---- verif/lag_peer.sv ----
`default_nettype none
module lag_peer
   import lag_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Role and attached ports
   input wire logic peer_active,
   input wire logic [NPORT-1:0] attached,
   // Negotiation packets
   input wire logic [NPORT-1:0] pdu_tx,
   output logic [NPORT-1:0] pdu_rx
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [NPORT-1:0] d1, d2;
   logic [3:0] tick;
   // Answers three cycles late; speaks unasked only when active
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         d1 <= '0;
         d2 <= '0;
         tick <= 4'h0;
         pdu_rx <= '0;
      end else begin
         d1 <= pdu_tx & attached;
         d2 <= d1;
         tick <= tick + 4'h1;
         pdu_rx <= (d2 | {NPORT{peer_active && tick == 4'hF}}) & attached;
      end
   end
endmodule
`default_nettype wire

// ---- verif/lag_selector_props.sv ----
`default_nettype none
module lag_chk
   import lag_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Ports and frames
   input wire logic [NPORT-1:0] link_up,
   input wire logic [NPORT-1:0] full_dup,
   input wire logic [NPORT-1:0] pdu_tx,
   input wire logic [NPORT-1:0] member_act,
   input wire logic frm_valid,
   input wire logic [3:0] frm_dst,
   input wire logic egr_valid,
   input wire logic [3:0] egr_port
);
   timeunit 1ns;
   timeprecision 100ps;
   // Usable ports; derived state may lag them by a few cycles
   wire logic [NPORT-1:0] ok;
   wire logic rd_take;
   wire logic frm_ok;
   assign ok = link_up & full_dup;
   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   assign frm_ok = frm_valid && (frm_dst < 4'hC);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // Zero wait states, always okay; read data, egress, packet and member rules
   bus_ready_a: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   rdata_idle_a: assert property (!$past(rd_take) |-> hrdata == 32'h0)
      else $error("read data outside a data phase");
   egr_follow_a: assert property (frm_ok |=> egr_valid)
      else $error("frame got no egress decision");
   egr_refuse_a: assert property (!frm_ok |=> !egr_valid)
      else $error("egress decision without a frame");
   egr_hold_a: assert property (!frm_valid |=> $stable(egr_port))
      else $error("egress port moved without a frame");
   egr_range_a: assert property (egr_valid |-> egr_port < 4'hC)
      else $error("egress port out of range");
   pdu_pulse_a: assert property ((pdu_tx & $past(pdu_tx)) == '0)
      else $error("negotiation packet request longer than a cycle");
   pdu_link_a: assert property ((pdu_tx & ~(ok | $past(ok) |
      $past(ok, 2) | $past(ok, 3))) == '0)
      else $error("packet sent on an unusable port");
   member_link_a: assert property ((member_act & ~(ok | $past(ok) |
      $past(ok, 2) | $past(ok, 3))) == '0)
      else $error("unusable port left active");

   // Main scenarios reached
   frame_c: cover property (frm_ok ##1 egr_valid);
   pdu_c: cover property (pdu_tx != '0);
   bundle_c: cover property (member_act != '0);
endmodule

bind lag_selector lag_chk u_chk (.sys_clk, .resetn, .hsel, .htrans,
   .hwrite, .hready, .hrdata, .hreadyout, .hresp, .link_up, .full_dup,
   .pdu_tx, .member_act, .frm_valid, .frm_dst, .egr_valid, .egr_port);
`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none
module tb
   import lag_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Short second keeps the slow period inside the run
   localparam int SEC = 20;
   logic sys_clk = 1'b0;
   logic resetn, hsel, hwrite, frm_valid, egr_valid, peer_active;
   logic hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, frm_sip;
   logic [1:0] htrans;
   wire logic hready;
   logic [NPORT-1:0] link_up, full_dup, pdu_rx, pdu_tx, member_act;
   logic [2*NPORT-1:0] port_speed;
   logic [12*NPORT-1:0] port_vlan;
   logic [16*NPORT-1:0] partner_id;
   logic [3:0] frm_dst, egr_port;
   logic [47:0] frm_dmac, frm_smac;
   logic [15:0] frm_sport;
   int fail_count = 0;
   int total_checks = 0;
   assign hready = hreadyout;

   lag_selector #(.SEC_CYCLES(SEC), .MAX_ACTIVE(2)) DUT (
      .sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hready, .hwdata, .hrdata, .hreadyout, .hresp, .link_up, .full_dup,
      .port_speed, .port_vlan, .partner_id, .pdu_rx, .pdu_tx, .member_act,
      .frm_valid, .frm_dst, .frm_smac, .frm_dmac,
      .frm_sip, .frm_dip(32'h0A00_0002), .frm_sport,
      .frm_dport(16'h0050), .egr_valid, .egr_port);
   lag_peer PEER (.sys_clk, .resetn, .peer_active, .attached(12'hFF0),
      .pdu_tx, .pdu_rx);

   always #2.5 sys_clk = ~sys_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] ad(input logic [2:0] rg, input int p);
      return (32'(rg) << RG_LSB) | (32'(p) << IDX_LSB);
   endfunction

   // Address phase, then data phase, each held until ready is seen
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] x);
      bus(1'b0, a, 32'h0, x);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] x;
      rd(a, x);
      chk(x, e);
   endtask
   task automatic frame(input logic [3:0] d, input logic [47:0] dm,
                        input logic [15:0] sp, output logic [3:0] p,
                        output logic v);
      frm_valid <= 1'b1;
      frm_dst <= d;
      frm_dmac <= dm;
      frm_sport <= sp;
      @(posedge sys_clk);
      frm_valid <= 1'b0;
      #1 v = egr_valid;
      p = egr_port;
      @(posedge sys_clk);
   endtask
   // Cycles between two packet requests on one port
   task automatic gap(input int i, output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pdu_tx[i] !== 1'b1 && n < 2000);
   endtask

   task automatic t_reset;
      logic [31:0] v;
      rd(ad(RG_HASH, 0), v);
      chk(v[HB_SMAC], 1'b1);
      chk(v[HB_DMAC], 1'b0);
      chk(v[HB_IP], 1'b1);
      chk(v[HB_L4], 1'b1);
      for (int p = 0; p < NPORT; p++) begin
         rdc(ad(RG_GRP, p), 32'h0);
         rdc(ad(RG_LCFG, p), 32'h0001_0000);
         rdc(ad(RG_PRIO, p), 32'h0000_8000);
      end
      rdc(32'h0000_0200, 32'h0);
      chk(member_act, 32'h0);
   endtask

   // Group 1 gets ports 0..3; port 2 is half duplex, port 3 slower
   task automatic t_static;
      logic [31:0] x;
      logic [3:0] p0, p;
      logic v;
      for (int i = 0; i < 4; i++) wr(ad(RG_GRP, i), 32'h1);
      wr(ad(RG_GRP, 0), 32'h7);
      rdc(ad(RG_GRP, 0), 32'h1);
      for (int i = 0; i < 4; i++) begin
         rd(ad(RG_STAT, i), x);
         chk(x[SB_STAT], i < 2);
      end
      frame(4'h5, 48'h0, 16'h1, p, v);
      chk({v, p}, 5'h15);
      frame(4'hC, 48'h0, 16'h1, p, v);
      chk(v, 1'b0);
      frame(4'h0, 48'h0, 16'h1, p0, v);
      chk(p0 < 4'h2, 1'b1);
      for (int i = 1; i < 4; i++) begin
         frame(4'h1, 48'(i), 16'h1, p, v);
         chk(p, p0);
      end
      wr(ad(RG_HASH, 0), 32'h2);
      rdc(ad(RG_HASH, 0), 32'h2);
      frame(4'h0, 48'h0, 16'h1, p0, v);
      frame(4'h0, 48'h1, 16'h1, p, v);
      chk(p ^ p0, 4'h1);
      frame(4'h0, 48'h1, 16'h7, p0, v);
      chk(p0, p);
      wr(ad(RG_HASH, 0), 32'h1);
      frame(4'h0, 48'h1, 16'h7, p0, v);
      frm_smac <= 48'h1;
      frame(4'h0, 48'h1, 16'h7, p, v);
      chk(p ^ p0, 4'h1);
      wr(ad(RG_HASH, 0), 32'hD);
   endtask

   // Ports 4..8 and 11 negotiate; only two may be active at once
   task automatic t_lacp;
      logic [31:0] x;
      wr(ad(RG_PRIO, 11), 32'h1);
      wr(ad(RG_PRIO, 11), 32'h0);
      rdc(ad(RG_PRIO, 11), 32'h1);
      for (int p = 4; p < 12; p++) begin
         if (p < 9 || p > 10) wr(ad(RG_LCFG, p), 32'h1);
      end
      repeat (80) @(posedge sys_clk);
      chk(member_act, 32'h0813);
      rd(ad(RG_STAT, 5), x);
      chk(x[SB_BUND], 1'b1);
      rd(ad(RG_STAT, 6), x);
      chk(x[SB_BUND], 1'b0);
      rd(ad(RG_STAT, 7), x);
      chk({x[SB_BUND], x[31:16]}, 17'h0_0002);
      rd(ad(RG_STAT, 8), x);
      chk(x[SB_BUND], 1'b0);
      rd(ad(RG_STAT, 4), x);
      chk(x[31:16], 16'h3);
      port_speed[17:16] <= SPD_10;
      wr(ad(RG_LCFG, 5), 32'h0007_0009);
      wr(ad(RG_LCFG, 5), 32'h0000_0009);
      rd(ad(RG_STAT, 8), x);
      chk(x[31:16], 16'h1);
      rd(ad(RG_STAT, 5), x);
      chk(x[31:16], 16'h7);
      wr(ad(RG_LCFG, 11), 32'h0);
      repeat (8) @(posedge sys_clk);
      chk(member_act, 32'h3);
   endtask

   task automatic t_period;
      int n;
      gap(4, n);
      gap(4, n);
      chk(n, SEC * FAST_PERIOD_S);
      wr(ad(RG_LCFG, 4), 32'h5);
      gap(4, n);
      gap(4, n);
      chk(n, SEC * SLOW_PERIOD_S);
   endtask

   // Passive ports 9 and 10 facing a peer that is passive, then active
   task automatic t_passive;
      logic [NPORT-1:0] seen;
      seen = '0;
      wr(ad(RG_LCFG, 9), 32'h3);
      wr(ad(RG_LCFG, 10), 32'h3);
      repeat (100) @(posedge sys_clk) seen = seen | pdu_tx;
      chk(seen[10:9], 2'h0);
      chk(member_act[10:9], 2'h0);
      peer_active <= 1'b1;
      repeat (100) @(posedge sys_clk) seen = seen | pdu_tx;
      chk(seen[10:9], 2'h3);
      chk(member_act[10:9], 2'h3);
      link_up[9] <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk(member_act[10:9], 2'h0);
   endtask

   task results;
      if (fail_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Port 2 half duplex, ports 3 and 7 at 100M, port 8 other VLAN
   initial begin
      resetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hwdata = 32'h0;
      link_up = '1;
      full_dup = 12'hFFB;
      port_speed = 24'hAA6A6A;
      port_vlan = '0;
      port_vlan[96 +: 12] = 12'h005;
      partner_id = {NPORT{16'h0001}};
      partner_id[96 +: 16] = 16'h0003;
      partner_id[144 +: 32] = 32'h0002_0002;
      frm_valid = 1'b0;
      frm_dst = 4'h0;
      frm_dmac = 48'h0;
      frm_smac = 48'h0000_1234_5678;
      frm_sip = 32'h0A00_0001;
      frm_sport = 16'h0;
      peer_active = 1'b0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_static();
      t_lacp();
      t_period();
      t_passive();
      results();
   end

   // Whole run is a few thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      results();
   end
endmodule
`default_nettype wire
